// ### hdl/independent_watchdog_regs.sv
// independent watchdog: key register, protected prescale and reload, down-counter
// assumes register strobes are synchronous single-cycle pulses on clk_sys
`timescale 1ns/100ps
`default_nettype none
module independent_watchdog_regs
  import independent_watchdog_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        hwStartEn,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  output var  logic [31:0] regRdata_q,
  output var  logic        regRvalid_q,
  output var  logic        wdtReset_q
);

  logic             lowSpeedTick;
  logic             decTick;
  logic [7:0]       divLimit;
  logic             keyWr;
  logic [15:0]      keyVal;
  logic             unlock_q;
  logic             running_q;
  logic             frozen_q;
  logic             hwSeen_q;
  logic [CNT_W-1:0] count_q;
  logic [PRE_W-1:0] preCode_q;
  logic [PRE_W-1:0] prePend_q;
  logic             preBusy_q;
  logic [1:0]       preXfer_q;
  logic [CNT_W-1:0] relVal_q;
  logic [CNT_W-1:0] relPend_q;
  logic             relBusy_q;
  logic [1:0]       relXfer_q;

  assign keyWr  = regWrite && (regAddr == OFF_KEY);
  assign keyVal = regWdata[15:0];

  // low-speed clock stands in as an enable from the system clock
  tick_divider #(.W(TICK_W)) lowSpeedDiv (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .en      (1'b1),
    .limit   (LOW_SPEED_LIMIT),
    .tick    (lowSpeedTick)
  );

  always_comb begin
    if (preCode_q > PRESCALE_MAX_CODE) begin
      divLimit = DIV_MAX_LIMIT;
    end else begin
      divLimit = 8'((({24'h0, DIV_BASE_LIMIT} + 32'h1) << preCode_q) - 32'h1);
    end
  end

  tick_divider #(.W(8)) prescaleDiv (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .en      (lowSpeedTick),
    .limit   (divLimit),
    .tick    (decTick)
  );

  // write protection
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      unlock_q <= 1'b0;
    end else if (keyWr) begin
      unlock_q <= (keyVal == KEY_UNLOCK);
    end
  end

  // prescale update: held pending until it has crossed on slow ticks
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      preCode_q <= PRESCALE_RESET;
      prePend_q <= PRESCALE_RESET;
      preBusy_q <= 1'b0;
      preXfer_q <= 2'h0;
    end else if (regWrite && regAddr == OFF_PRESCALE && unlock_q && !preBusy_q) begin
      prePend_q <= regWdata[PRE_W-1:0];
      preBusy_q <= 1'b1;
      preXfer_q <= 2'h0;
    end else if (preBusy_q && lowSpeedTick) begin
      if (preXfer_q == XFER_TICKS - 2'h1) begin
        preCode_q <= prePend_q;
        preBusy_q <= 1'b0;
      end else begin
        preXfer_q <= preXfer_q + 2'h1;
      end
    end
  end

  // reload update, same crossing scheme
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      relVal_q  <= RELOAD_RESET;
      relPend_q <= RELOAD_RESET;
      relBusy_q <= 1'b0;
      relXfer_q <= 2'h0;
    end else if (regWrite && regAddr == OFF_RELOAD && unlock_q && !relBusy_q) begin
      relPend_q <= regWdata[CNT_W-1:0];
      relBusy_q <= 1'b1;
      relXfer_q <= 2'h0;
    end else if (relBusy_q && lowSpeedTick) begin
      if (relXfer_q == XFER_TICKS - 2'h1) begin
        relVal_q  <= relPend_q;
        relBusy_q <= 1'b0;
      end else begin
        relXfer_q <= relXfer_q + 2'h1;
      end
    end
  end

  // run and freeze state; hardware start caught one edge after release
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      running_q <= 1'b0;
      hwSeen_q  <= 1'b0;
      frozen_q  <= 1'b0;
    end else begin
      hwSeen_q <= 1'b1;
      if (!hwSeen_q && hwStartEn) begin
        running_q <= 1'b1;
      end else if (keyWr && keyVal == KEY_START) begin
        running_q <= 1'b1;
      end
      if (keyWr && keyVal == KEY_FREEZE) begin
        frozen_q <= 1'b1;
      end else if (keyWr && keyVal == KEY_RESTORE) begin
        frozen_q <= 1'b0;
      end
    end
  end

  // down-counter; unknown keys fall through untouched
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= CNT_ALL_ONES;
    end else if (keyWr && keyVal == KEY_START && !running_q) begin
      count_q <= CNT_ALL_ONES;
    end else if (keyWr && keyVal == KEY_RELOAD) begin
      count_q <= relVal_q;
    end else if (running_q && !frozen_q && decTick && count_q != CNT_ZERO) begin
      count_q <= count_q - 12'h1;
    end
  end

  // reset request stays until system reset clears the block
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wdtReset_q <= 1'b0;
    end else if (running_q && count_q == CNT_ZERO) begin
      wdtReset_q <= 1'b1;
    end
  end

  // read path, one cycle latency
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      regRdata_q  <= 32'h0;
      regRvalid_q <= 1'b0;
    end else begin
      regRvalid_q <= regRead;
      if (regRead) begin
        case (regAddr)
          OFF_PRESCALE: regRdata_q <= {29'h0, preCode_q};
          OFF_RELOAD:   regRdata_q <= {20'h0, relVal_q};
          OFF_STATUS:   regRdata_q <= {30'h0, relBusy_q, preBusy_q};
          default:      regRdata_q <= 32'h0;
        endcase
      end
    end
  end

  sequence keyWrite(logic [15:0] k);
    keyWr && keyVal == k;
  endsequence

  sequence protectedWrite(logic [3:0] off);
    regWrite && regAddr == off && !unlock_q;
  endsequence

  AST_START: assert property (@(posedge clk_sys) disable iff (!rst_b)
    keyWrite(KEY_START) ##0 !running_q |=> running_q && count_q == CNT_ALL_ONES)
    else $error("start key did not start counter from all ones");

  AST_START_RUNNING: assert property (@(posedge clk_sys) disable iff (!rst_b)
    keyWrite(KEY_START) ##0 running_q ##0 !decTick |=> count_q == $past(count_q))
    else $error("start key disturbed a running counter");

  AST_RELOAD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    keyWrite(KEY_RELOAD) |=> count_q == $past(relVal_q) && !unlock_q)
    else $error("reload key did not load reload value");

  AST_UNLOCK: assert property (@(posedge clk_sys) disable iff (!rst_b)
    keyWrite(KEY_UNLOCK) |=> unlock_q)
    else $error("unlock key did not open protection");

  AST_RELOCK: assert property (@(posedge clk_sys) disable iff (!rst_b)
    keyWr && keyVal != KEY_UNLOCK |=> !unlock_q)
    else $error("other key left protection open");

  AST_FREEZE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    keyWrite(KEY_FREEZE) ##1 (!keyWr [*3]) |=> count_q == $past(count_q, 3) && frozen_q)
    else $error("frozen counter changed");

  AST_RESTORE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    keyWrite(KEY_RESTORE) |=> !frozen_q)
    else $error("restore key did not release freeze");

  AST_PRE_LOCKED: assert property (@(posedge clk_sys) disable iff (!rst_b)
    protectedWrite(OFF_PRESCALE) ##0 !preBusy_q |=> !preBusy_q && $stable(prePend_q))
    else $error("locked prescale write was taken");

  AST_REL_LOCKED: assert property (@(posedge clk_sys) disable iff (!rst_b)
    protectedWrite(OFF_RELOAD) ##0 !relBusy_q |=> !relBusy_q && $stable(relPend_q))
    else $error("locked reload write was taken");

  AST_PRE_DONE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    preBusy_q && lowSpeedTick && preXfer_q == XFER_TICKS - 2'h1
      |=> !preBusy_q && preCode_q == $past(prePend_q))
    else $error("prescale transfer did not complete");

  AST_REL_DONE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    relBusy_q && lowSpeedTick && relXfer_q == XFER_TICKS - 2'h1
      |=> !relBusy_q && relVal_q == $past(relPend_q))
    else $error("reload transfer did not complete");

  AST_DECREMENT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    running_q && !frozen_q && decTick && count_q != CNT_ZERO && !keyWr
      |=> count_q == $past(count_q) - 12'h1)
    else $error("counter missed a decrement");

  AST_EXPIRE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    running_q && count_q == CNT_ZERO |=> wdtReset_q)
    else $error("expiry did not request reset");

  AST_KEY_READ: assert property (@(posedge clk_sys) disable iff (!rst_b)
    regRead && regAddr == OFF_KEY |=> regRvalid_q && regRdata_q == 32'h0)
    else $error("key register read not zero");

endmodule : independent_watchdog_regs
`default_nettype wire

// ### hdl/independent_watchdog_pkg.sv
// constants, register map and key codes of the independent watchdog
// assumes a single 125 MHz system clock; the low-speed tick is derived from it
//
// Behaviour
// - start key starts counter; no effect if running
// - reload key loads counter with reload value
// - unlock key opens prescale and reload writes
// - freeze key halts the counter
// - restore key releases the freeze
// - prescale writes need unlock and idle busy flag
// - prescale code picks divide 4 to 256
// - prescale read returns slow-domain value
// - reload writes need unlock and idle busy flag
// - reload read returns slow-domain value
// - status bit 1 busy during reload transfer
// - status bit 0 busy during prescale transfer
// - running counter at zero requests system reset
// - any other key restores write protection
// - counting starts from all ones
// - one decrement per prescaled low-speed period
package independent_watchdog_pkg;

  localparam int          SYS_CLK_HZ   = 125000000;
  localparam int          LOW_SPEED_HZ = 40000;
  localparam int          LOW_SPEED_DIV = SYS_CLK_HZ / LOW_SPEED_HZ;
  localparam int          TICK_W       = 12;
  localparam logic [11:0] LOW_SPEED_LIMIT = 12'(LOW_SPEED_DIV - 1);

  localparam logic [3:0]  OFF_KEY      = 4'h0;
  localparam logic [3:0]  OFF_PRESCALE = 4'h4;
  localparam logic [3:0]  OFF_RELOAD   = 4'h8;
  localparam logic [3:0]  OFF_STATUS   = 4'hc;

  localparam logic [15:0] KEY_START    = 16'hcccc;
  localparam logic [15:0] KEY_RELOAD   = 16'haaaa;
  localparam logic [15:0] KEY_UNLOCK   = 16'h5555;
  localparam logic [15:0] KEY_FREEZE   = 16'h4567;
  localparam logic [15:0] KEY_RESTORE  = 16'h89ab;

  localparam int          CNT_W        = 12;
  localparam int          PRE_W        = 3;
  localparam logic [11:0] CNT_ALL_ONES = 12'hfff;
  localparam logic [11:0] CNT_ZERO     = 12'h000;
  localparam logic [11:0] RELOAD_RESET = 12'hfff;
  localparam logic [2:0]  PRESCALE_RESET = 3'h0;
  localparam logic [2:0]  PRESCALE_MAX_CODE = 3'h5;
  localparam logic [7:0]  DIV_BASE_LIMIT = 8'h03;
  localparam logic [7:0]  DIV_MAX_LIMIT  = 8'hff;

  localparam int          STS_PRE_BIT  = 0;
  localparam int          STS_REL_BIT  = 1;
  localparam logic [1:0]  XFER_TICKS   = 2'h2;

endpackage : independent_watchdog_pkg

// ### hdl/tick_divider.sv
// divider that turns enable pulses into one tick every limit+1 pulses
// assumes limit is stable or changes only between ticks
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         en,
  input  wire logic [W-1:0] limit,
  output var  logic         tick
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (en) begin
        // >= so a shrinking limit never strands the count
        if (cnt_q >= limit) begin
          cnt_q <= '0;
          tick  <= 1'b1;
        end else begin
          cnt_q <= cnt_q + W'(1);
        end
      end
    end
  end

endmodule : tick_divider
`default_nettype wire

// ### tb/tb.sv
// register-level bench for the independent watchdog: lock, transfers, freeze, expiry
// assumes the low-speed enable every 3125 clocks and the one-cycle read latency
`timescale 1ns/100ps
`default_nettype none
module tb;
  import independent_watchdog_pkg::*;
  logic        clk_sys;
  logic        rst_b;
  logic        hwStartEn;
  logic        regWrite;
  logic        regRead;
  logic [3:0]  regAddr;
  logic [31:0] regWdata;
  logic [31:0] regRdata_q;
  logic        regRvalid_q;
  logic        wdtReset_q;
  logic [31:0] rdVal;
  int          err_total;
  int          samples_checked;
  int          i;

  independent_watchdog_regs dut (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .hwStartEn   (hwStartEn),
    .regWrite    (regWrite),
    .regRead     (regRead),
    .regAddr     (regAddr),
    .regWdata    (regWdata),
    .regRdata_q  (regRdata_q),
    .regRvalid_q (regRvalid_q),
    .wdtReset_q  (wdtReset_q)
  );

  always #4 clk_sys = ~clk_sys;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr  <= addr;
    regWdata <= data;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr

  // read strobe sampled at one edge, data valid just after it
  task automatic rd(input logic [3:0] addr, output logic [31:0] data);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= addr;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    chk("read valid", {31'h0, regRvalid_q}, 32'h1);
    data = regRdata_q;
  endtask : rd

  task automatic rdchk(input string name, input logic [3:0] addr, input logic [31:0] exp);
    rd(addr, rdVal);
    chk(name, rdVal, exp);
  endtask : rdchk

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    hwStartEn = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 4'h0;
    regWdata = 32'h0;
    err_total = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdchk("key reset", OFF_KEY, 32'h00000000);
    rdchk("prescale reset", OFF_PRESCALE, 32'h00000000);
    rdchk("reload reset", OFF_RELOAD, 32'h00000fff);
    rdchk("status reset", OFF_STATUS, 32'h00000000);
    rdchk("unmapped", 4'h2, 32'h00000000);
    wr(OFF_PRESCALE, 32'h3);
    rdchk("locked prescale", OFF_PRESCALE, 32'h0);
    $display("test reset and lock done");

    wr(OFF_KEY, {16'h0, KEY_UNLOCK});
    wr(OFF_PRESCALE, 32'h1);
    wr(OFF_PRESCALE, 32'h2);
    rdchk("prescale busy", OFF_STATUS, 32'h1);
    idle(7000);
    rdchk("prescale done", OFF_STATUS, 32'h0);
    rdchk("prescale value", OFF_PRESCALE, 32'h1);
    wr(OFF_PRESCALE, 32'h0);
    wr(OFF_RELOAD, 32'hfffff002);
    wr(OFF_RELOAD, 32'h9);
    rdchk("both busy", OFF_STATUS, 32'h3);
    idle(7000);
    rdchk("both done", OFF_STATUS, 32'h0);
    rdchk("reload value", OFF_RELOAD, 32'h2);
    rdchk("prescale back", OFF_PRESCALE, 32'h0);
    // unknown key must relock but start nothing
    wr(OFF_KEY, 32'h1234);
    wr(OFF_RELOAD, 32'h5);
    rdchk("relock status", OFF_STATUS, 32'h0);
    rdchk("relock reload", OFF_RELOAD, 32'h2);
    rdchk("key reads zero", OFF_KEY, 32'h0);
    chk("no reset yet", {31'h0, wdtReset_q}, 32'h0);
    $display("test transfers done");

    wr(OFF_KEY, {16'h0, KEY_START});
    wr(OFF_KEY, {16'h0, KEY_RELOAD});
    wr(OFF_KEY, {16'h0, KEY_FREEZE});
    // unfrozen, count 2 at divide 4 would expire within 25002 clocks
    idle(26000);
    #1;
    chk("frozen", {31'h0, wdtReset_q}, 32'h0);
    wr(OFF_KEY, {16'h0, KEY_RESTORE});
    wr(OFF_KEY, {16'h0, KEY_RELOAD});
    // a restart here would push expiry far past the wait below
    wr(OFF_KEY, {16'h0, KEY_START});
    idle(12400);
    #1;
    chk("before expiry", {31'h0, wdtReset_q}, 32'h0);
    for (i = 0; i < 13000 && wdtReset_q !== 1'b1; i++) begin
      @(posedge clk_sys);
    end
    #1;
    chk("expiry", {31'h0, wdtReset_q}, 32'h1);
    idle(100);
    #1;
    chk("sticky reset", {31'h0, wdtReset_q}, 32'h1);
    $display("test counting done");

    // mid-run reset with the hardware start option: runs with no start key
    idle(1);
    hwStartEn <= 1'b1;
    rst_b     <= 1'b0;
    idle(3);
    rst_b <= 1'b1;
    idle(2);
    #1;
    chk("request cleared", {31'h0, wdtReset_q}, 32'h0);
    chk("no read valid", {31'h0, regRvalid_q}, 32'h0);
    wr(OFF_KEY, {16'h0, KEY_UNLOCK});
    wr(OFF_PRESCALE, 32'h7);
    wr(OFF_RELOAD, 32'h0);
    idle(7000);
    rdchk("prescale slowest", OFF_PRESCALE, 32'h7);
    rdchk("reload zero", OFF_RELOAD, 32'h0);
    wr(OFF_KEY, {16'h0, KEY_RELOAD});
    idle(2);
    #1;
    chk("hardware start expiry", {31'h0, wdtReset_q}, 32'h1);
    $display("test hardware start done");
    end_of_test();
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    err_total++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
